// *** hdl/fwus_cfg.svh ***
`ifndef FWUS_CFG_SVH
`define FWUS_CFG_SVH

// response codes placed in the response code word
`define FWUS_RC_SUCCESS 32'h0000_0000
`define FWUS_RC_BAD_TAG 32'h0000_001e
`define FWUS_RC_FAILURE 32'h0000_0101
`define FWUS_RC_DISABLED 32'h0000_0120
`define FWUS_RC_AUTH_MISSING 32'h0000_0125
`define FWUS_RC_TOO_MANY_CONTEXTS 32'h0000_012e
`define FWUS_RC_REBOOT 32'h0000_0130
`define FWUS_RC_COMMAND_SIZE 32'h0000_0142
`define FWUS_RC_LOCALITY 32'h0000_0907
`define FWUS_RC_AUTH_FAIL 32'h0000_098e

// chunk position codes of a manifest chunk
`define FWUS_POS_LAST 8'h00
`define FWUS_POS_FIRST 8'h01
`define FWUS_POS_NEXT 8'h02

// largest manifest chunk or image block in bytes
`define FWUS_CHUNK_MAX 16'h0400

// attempt counter limits
`define FWUS_TOTAL_LIMIT 11'h4e8
`define FWUS_SAME_LIMIT 9'h100

// test-result record
`define FWUS_TEST_MASK 32'h0026_8070
`define FWUS_OPMODE_UPDATE 8'h01
`define FWUS_TEST_INFO 16'h0000
`define FWUS_TEST_LEN 8'h0b

// capability answer: count, buffer size, value
`define FWUS_CAP_COUNT 32'h0000_0001
`define FWUS_CAP_SIZE 16'h0004
`define FWUS_CAP_LEN 8'h0a
`define FWUS_PROP_OPMODE 32'h0000_0000

// response word layout
`define FWUS_PAYLOAD_W 88
`define FWUS_RSP_W 128

`endif

// *** hdl/fwus_pkg.sv ***
package fwus_pkg;

	typedef enum logic [2:0] {
		FWUS_CMD_FINALIZE = 3'b000,
		FWUS_CMD_MANIFEST = 3'b001,
		FWUS_CMD_IMAGE = 3'b010,
		FWUS_CMD_ABORT = 3'b011,
		FWUS_CMD_GETCAP = 3'b100,
		FWUS_CMD_SELFTEST = 3'b101,
		FWUS_CMD_TESTRESULT = 3'b110
	} fwus_cmd_t;

	typedef enum logic [2:0] {
		FWUS_PH_IDLE = 3'b000,
		FWUS_PH_CHAIN = 3'b001,
		FWUS_PH_MAN_OK = 3'b010,
		FWUS_PH_DATA = 3'b011,
		FWUS_PH_FINAL = 3'b100
	} fwus_phase_t;

endpackage

// *** hdl/fwus_buf.sv ***
`timescale 1ns/1ps
`default_nettype none

// two-entry first-in first-out holding stage
module fwus_buf #(
	parameter int WIDTH = 128
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] slot [0:1];
	logic [1:0] count;
	logic wr_ptr;
	logic rd_ptr;
	logic push;
	logic pop;

	assign in_ready = (count != 2'd2);
	assign out_valid = (count != 2'd0);
	assign out_data = slot[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk_sys) begin
		if (push) begin
			slot[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			count <= 2'd0;
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr <= ~wr_ptr;
			end
			if (pop) begin
				rd_ptr <= ~rd_ptr;
			end
			if (push && !pop) begin
				count <= count + 2'd1;
			end else if (pop && !push) begin
				count <= count - 2'd1;
			end
		end
	end

endmodule

`default_nettype wire

// *** hdl/fwus_seq.sv ***
`include "fwus_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module fwus_seq (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire fwus_pkg::fwus_cmd_t cmd_code,
	input wire logic cmd_tag_ok,
	input wire logic cmd_size_ok,
	input wire logic cmd_locality_ok,
	input wire logic [15:0] cmd_len,
	input wire logic [7:0] cmd_position,
	input wire logic cmd_reserved_zero,
	input wire logic [31:0] cmd_property,
	input wire logic update_mode,
	input wire logic manifest_verify_ok,
	input wire logic newer_version,
	input wire logic restore_abort_lock,
	input wire logic [31:0] cap_value,
	input wire logic selftest_done,
	input wire logic [31:0] selftest_pass,
	output logic rsp_valid,
	input wire logic rsp_ready,
	output logic [31:0] rsp_code,
	output logic [7:0] rsp_len,
	output logic [87:0] rsp_payload,
	output logic selftest_start,
	output logic image_block_write,
	output logic finalize_start,
	output logic abort_start,
	output logic attempt_count,
	output logic manifest_done,
	output logic data_started,
	output logic abort_allowed
);
	import fwus_pkg::*;

	fwus_phase_t phase;
	fwus_phase_t next_phase;
	logic [10:0] total_attempts;
	logic [8:0] same_attempts;
	logic [31:0] passed;
	logic [31:0] not_run;
	logic lock_seen;
	logic nv_abort_lock;
	logic take;
	logic [31:0] next_rc;
	logic [7:0] next_len;
	logic [87:0] next_payload;
	logic next_selftest;
	logic next_image;
	logic next_finalize;
	logic next_abort;
	logic next_attempt;
	logic [`FWUS_RSP_W-1:0] rsp_word;
	logic buf_in_ready;

	function automatic logic frame_bad(input logic tag_ok, input logic size_ok,
			input logic loc_ok, input logic [15:0] len, output logic [31:0] rc);
		frame_bad = 1'b1;
		if (!tag_ok) begin
			rc = `FWUS_RC_BAD_TAG;
		end else if (!size_ok || (len > `FWUS_CHUNK_MAX)) begin
			rc = `FWUS_RC_COMMAND_SIZE;
		end else if (!loc_ok) begin
			rc = `FWUS_RC_LOCALITY;
		end else begin
			rc = `FWUS_RC_SUCCESS;
			frame_bad = 1'b0;
		end
	endfunction

	assign take = cmd_valid && cmd_ready;
	assign cmd_ready = buf_in_ready;
	assign manifest_done = (phase == FWUS_PH_MAN_OK) || (phase == FWUS_PH_DATA);
	assign data_started = (phase == FWUS_PH_DATA);
	assign abort_allowed = !data_started && !nv_abort_lock && (phase != FWUS_PH_FINAL);

	// restored abort lock caught once after reset release
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lock_seen <= 1'b0;
			nv_abort_lock <= 1'b0;
		end else if (!lock_seen) begin
			lock_seen <= 1'b1;
			nv_abort_lock <= restore_abort_lock ||
				(take && (cmd_code == FWUS_CMD_IMAGE) && (next_rc == `FWUS_RC_SUCCESS));
		end else if (take && (cmd_code == FWUS_CMD_IMAGE) && (next_rc == `FWUS_RC_SUCCESS)) begin
			nv_abort_lock <= 1'b1;
		end
	end

	always_comb begin
		logic [31:0] frc;
		logic bad;
		frc = `FWUS_RC_SUCCESS;
		bad = 1'b0;
		next_phase = phase;
		next_rc = `FWUS_RC_SUCCESS;
		next_len = 8'h00;
		next_payload = '0;
		next_selftest = 1'b0;
		next_image = 1'b0;
		next_finalize = 1'b0;
		next_abort = 1'b0;
		next_attempt = 1'b0;
		bad = frame_bad(cmd_tag_ok, cmd_size_ok, cmd_locality_ok, cmd_len, frc);
		if (phase == FWUS_PH_FINAL) begin
			next_rc = `FWUS_RC_REBOOT;
		end else begin
			case (cmd_code)
				FWUS_CMD_FINALIZE: begin
					if (!cmd_tag_ok) begin
						next_rc = `FWUS_RC_BAD_TAG;
					end else if (!data_started || !cmd_reserved_zero) begin
						next_rc = `FWUS_RC_FAILURE;
					end else begin
						next_rc = `FWUS_RC_REBOOT;
						next_finalize = 1'b1;
						next_phase = FWUS_PH_FINAL;
					end
				end
				FWUS_CMD_MANIFEST: begin
					if (bad) begin
						next_rc = frc;
					end else if (phase == FWUS_PH_MAN_OK) begin
						next_rc = `FWUS_RC_DISABLED;
					end else if (phase == FWUS_PH_DATA) begin
						next_rc = `FWUS_RC_TOO_MANY_CONTEXTS;
					end else if (!update_mode) begin
						next_rc = `FWUS_RC_FAILURE;
					end else if ((total_attempts >= `FWUS_TOTAL_LIMIT) ||
							(same_attempts >= `FWUS_SAME_LIMIT)) begin
						next_rc = `FWUS_RC_FAILURE;
					end else if (cmd_position == `FWUS_POS_FIRST) begin
						next_phase = FWUS_PH_CHAIN;
					end else if (phase != FWUS_PH_CHAIN) begin
						next_rc = `FWUS_RC_FAILURE;
					end else if (cmd_position == `FWUS_POS_NEXT) begin
						next_phase = FWUS_PH_CHAIN;
					end else if (cmd_position == `FWUS_POS_LAST) begin
						next_attempt = 1'b1;
						if (manifest_verify_ok) begin
							next_phase = FWUS_PH_MAN_OK;
						end else begin
							next_rc = `FWUS_RC_AUTH_FAIL;
							next_phase = FWUS_PH_IDLE;
						end
					end else begin
						next_rc = `FWUS_RC_FAILURE;
						next_phase = FWUS_PH_IDLE;
					end
				end
				FWUS_CMD_IMAGE: begin
					if (bad) begin
						next_rc = frc;
					end else if (!manifest_done) begin
						next_rc = `FWUS_RC_AUTH_MISSING;
					end else begin
						next_image = 1'b1;
						next_phase = FWUS_PH_DATA;
					end
				end
				FWUS_CMD_ABORT: begin
					if (bad) begin
						next_rc = frc;
					end else if (!abort_allowed) begin
						next_rc = `FWUS_RC_DISABLED;
					end else begin
						next_abort = 1'b1;
						next_phase = FWUS_PH_IDLE;
					end
				end
				FWUS_CMD_GETCAP: begin
					next_len = `FWUS_CAP_LEN;
					next_payload[87:8] = {`FWUS_CAP_COUNT, `FWUS_CAP_SIZE,
						(cmd_property == `FWUS_PROP_OPMODE) ?
						{24'h00_0000, `FWUS_OPMODE_UPDATE} : cap_value};
				end
				FWUS_CMD_SELFTEST: begin
					next_selftest = 1'b1;
				end
				FWUS_CMD_TESTRESULT: begin
					next_len = `FWUS_TEST_LEN;
					next_payload = {passed, not_run, `FWUS_TEST_INFO, `FWUS_OPMODE_UPDATE};
				end
				default: begin
					next_rc = `FWUS_RC_FAILURE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			phase <= FWUS_PH_IDLE;
		end else if (take) begin
			phase <= next_phase;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			total_attempts <= 11'h000;
			same_attempts <= 9'h000;
		end else if (take && next_attempt) begin
			total_attempts <= total_attempts + 11'h001;
			same_attempts <= newer_version ? 9'h001 : same_attempts + 9'h001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			passed <= 32'h0000_0000;
			not_run <= `FWUS_TEST_MASK;
		end else if (selftest_done) begin
			passed <= selftest_pass & `FWUS_TEST_MASK;
			not_run <= 32'h0000_0000;
		end else if (take && next_selftest) begin
			not_run <= `FWUS_TEST_MASK;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			selftest_start <= 1'b0;
			image_block_write <= 1'b0;
			finalize_start <= 1'b0;
			abort_start <= 1'b0;
			attempt_count <= 1'b0;
		end else begin
			selftest_start <= take && next_selftest;
			image_block_write <= take && next_image;
			finalize_start <= take && next_finalize;
			abort_start <= take && next_abort;
			attempt_count <= take && next_attempt;
		end
	end

	assign rsp_word = {next_rc, next_len, next_payload};

	// answers wait here while the host stalls
	fwus_buf #(
		.WIDTH(`FWUS_RSP_W)
	) u_rsp_buf (
		.clk_sys(clk_sys),
		.rst(rst),
		.in_valid(take),
		.in_ready(buf_in_ready),
		.in_data(rsp_word),
		.out_valid(rsp_valid),
		.out_ready(rsp_ready),
		.out_data({rsp_code, rsp_len, rsp_payload})
	);

endmodule

`default_nettype wire

// *** bench/fwus_seq_properties.sv ***
`timescale 1ns/1ps
`default_nettype none

module fwus_seq_properties (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire fwus_pkg::fwus_cmd_t cmd_code,
	input wire logic cmd_tag_ok,
	input wire logic cmd_size_ok,
	input wire logic cmd_locality_ok,
	input wire logic [15:0] cmd_len,
	input wire logic rsp_valid,
	input wire logic rsp_ready,
	input wire logic [31:0] rsp_code,
	input wire logic image_block_write,
	input wire logic finalize_start,
	input wire logic abort_start,
	input wire logic attempt_count,
	input wire logic manifest_done,
	input wire logic data_started,
	input wire logic abort_allowed,
	input wire logic selftest_start
);
	import fwus_pkg::*;
	logic fin;
	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (rst);

	// after finalize every command answers reboot, so no block writes
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fin <= 1'b0;
		end else if (finalize_start) begin
			fin <= 1'b1;
		end
	end

	reset_state_a: assert property (
		$fell(rst) |-> !rsp_valid && cmd_ready && !manifest_done && !data_started)
		else $error("state not clear after reset");
	answer_next_a: assert property (
		cmd_valid && cmd_ready |=> rsp_valid) else $error("no answer after command");
	answer_hold_a: assert property (
		rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_code))
		else $error("answer dropped while stalled");
	image_write_a: assert property (
		cmd_valid && cmd_ready && cmd_code == FWUS_CMD_IMAGE && cmd_tag_ok && cmd_size_ok
		&& cmd_locality_ok && cmd_len <= 16'h0400 && (manifest_done || data_started) && !fin
		&& !finalize_start |=> image_block_write) else $error("image block not written");
	abort_lock_a: assert property (
		data_started && cmd_valid && cmd_ready && cmd_code == FWUS_CMD_ABORT
		|=> !abort_start && !abort_allowed) else $error("abort open after image data");
	selftest_run_a: assert property (
		cmd_valid && cmd_ready && cmd_code == FWUS_CMD_SELFTEST && !fin && !finalize_start
		|=> selftest_start) else $error("self-test not started");
	abort_gate_a: assert property (
		abort_start |-> $past(abort_allowed)) else $error("abort started while locked");
	count_pulse_a: assert property (
		attempt_count |=> !attempt_count) else $error("attempt counted twice");
	final_gate_a: assert property (
		finalize_start |-> $past(data_started)) else $error("finalize without image data");

	cover property (image_block_write);
	cover property (abort_start);
	cover property (finalize_start);
endmodule

`default_nettype wire

// *** bench/fwus_host_sink.sv ***
`timescale 1ns/1ps
`default_nettype none

module fwus_host_sink (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic slow,
	output logic rsp_ready
);
	logic [1:0] pace;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pace <= 2'h0;
		end else begin
			pace <= pace + 2'h1;
		end
	end

	assign rsp_ready = !slow || pace == 2'h3;
endmodule

`default_nettype wire

// *** bench/fwus_seq_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fwus_cfg.svh"

module fwus_seq_bench;
	import fwus_pkg::*;
	fwus_cmd_t cmd_code = FWUS_CMD_GETCAP;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic cmd_valid = 1'b0;
	logic cmd_tag_ok = 1'b1;
	logic cmd_size_ok = 1'b1;
	logic cmd_locality_ok = 1'b1;
	logic cmd_reserved_zero = 1'b1;
	logic manifest_verify_ok = 1'b1;
	logic restore_abort_lock = 1'b0;
	logic update_mode = 1'b1;
	logic [31:0] cmd_property = 32'h0000_0005;
	logic selftest_done = 1'b0;
	logic slow = 1'b0;
	logic big = 1'b0;
	logic cmd_ready, rsp_valid, rsp_ready;
	logic [7:0] cmd_position = 8'h00;
	logic [7:0] rsp_len;
	logic [7:0] xl = 8'h00;
	logic [15:0] cmd_len = 16'h0001;
	logic [31:0] cap_value = 32'h0;
	logic [31:0] selftest_pass = 32'h0;
	logic [31:0] rsp_code, r;
	logic [87:0] rsp_payload, xp;
	logic [87:0] xm = '0;
	logic [127:0] exp_q[$];
	logic [87:0] msk_q[$];
	logic [31:0] bad_rc[3] = '{`FWUS_RC_BAD_TAG, `FWUS_RC_COMMAND_SIZE, `FWUS_RC_LOCALITY};
	int mismatches = 0;
	int n_compared = 0;
	int cycles = 0;
	int seed = 18;
	int i;

	fwus_seq DUT (.clk_sys, .rst, .cmd_valid, .cmd_ready, .cmd_code, .cmd_tag_ok, .cmd_size_ok,
		.cmd_locality_ok, .cmd_len, .cmd_position, .cmd_reserved_zero,
		.cmd_property, .update_mode, .manifest_verify_ok,
		.newer_version(1'b0), .restore_abort_lock, .cap_value, .selftest_done, .selftest_pass,
		.rsp_valid, .rsp_ready, .rsp_code, .rsp_len, .rsp_payload, .selftest_start(),
		.image_block_write(), .finalize_start(), .abort_start(), .attempt_count(),
		.manifest_done(), .data_started(), .abort_allowed());
	fwus_host_sink host (.clk_sys, .rst, .slow, .rsp_ready);

	always #20 clk_sys = ~clk_sys;

	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic issue(input fwus_cmd_t c, input logic [7:0] p, input logic [31:0] rc);
		@(posedge clk_sys);
		cmd_code <= c;
		cmd_position <= p;
		cmd_len <= big ? 16'h0401 : 16'($random(seed) & 32'h3ff) + 16'h0001;
		cmd_valid <= 1'b1;
		@(negedge clk_sys);
		while (!cmd_ready) @(negedge clk_sys);
		@(posedge clk_sys);
		exp_q.push_back({rc, xl, xp});
		msk_q.push_back(xm);
		xl = 8'h00;
		xm = '0;
		cmd_valid <= 1'b0;
	endtask

	task automatic drain;
		for (i = 0; i < 200 && exp_q.size() > 0; i++) @(posedge clk_sys);
		if (exp_q.size() > 0) begin
			mismatches++;
			$display("[ERR] %0t answers still missing", $time);
		end
	endtask

	always @(negedge clk_sys) begin
		if (!rst && rsp_valid && rsp_ready) begin
			n_compared++;
			if (exp_q.size() == 0 || {rsp_code, rsp_len} !== exp_q[0][127:88] ||
				((rsp_payload ^ exp_q[0][87:0]) & msk_q[0]) !== '0) begin
				mismatches++;
				$display("[ERR] %0t answer %h len %h", $time, rsp_code, rsp_len);
			end
			if (exp_q.size() > 0) begin
				void'(exp_q.pop_front());
				void'(msk_q.pop_front());
			end
		end
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			close_out();
		end
	end

	initial begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		issue(FWUS_CMD_IMAGE, 8'h00, `FWUS_RC_AUTH_MISSING);
		update_mode <= 1'b0;
		issue(FWUS_CMD_MANIFEST, 8'h01, `FWUS_RC_FAILURE);
		update_mode <= 1'b1;
		issue(FWUS_CMD_MANIFEST, 8'h02, `FWUS_RC_FAILURE);
		for (int k = 0; k < 3; k++) begin
			{cmd_tag_ok, cmd_size_ok, cmd_locality_ok} <= ~(3'b100 >> k);
			issue(FWUS_CMD_MANIFEST, 8'h01, bad_rc[k]);
			issue(FWUS_CMD_ABORT, 8'h00, bad_rc[k]);
		end
		{cmd_tag_ok, cmd_size_ok, cmd_locality_ok} <= 3'b111;
		manifest_verify_ok <= 1'b0;
		issue(FWUS_CMD_MANIFEST, 8'h01, `FWUS_RC_SUCCESS);
		issue(FWUS_CMD_MANIFEST, 8'h02, `FWUS_RC_SUCCESS);
		issue(FWUS_CMD_MANIFEST, 8'h00, `FWUS_RC_AUTH_FAIL);
		manifest_verify_ok <= 1'b1;
		issue(FWUS_CMD_ABORT, 8'h00, `FWUS_RC_SUCCESS);
		for (int k = 0; k < 2; k++) begin
			issue(FWUS_CMD_MANIFEST, 8'h01, `FWUS_RC_SUCCESS);
			issue(FWUS_CMD_MANIFEST, 8'h00, `FWUS_RC_SUCCESS);
			if (k == 0) issue(FWUS_CMD_ABORT, 8'h00, `FWUS_RC_SUCCESS);
		end
		issue(FWUS_CMD_MANIFEST, 8'h01, `FWUS_RC_DISABLED);
		r = $random(seed);
		cap_value <= r;
		xl = `FWUS_CAP_LEN;
		xp = {32'h0000_0001, 16'h0004, r, 8'h00};
		xm = {{80{1'b1}}, 8'h00};
		issue(FWUS_CMD_GETCAP, 8'h00, `FWUS_RC_SUCCESS);
		cmd_property <= 32'h0000_0000;
		xl = `FWUS_CAP_LEN;
		xp = {32'h0000_0001, 16'h0004, 32'h0000_0001, 8'h00};
		xm = {{80{1'b1}}, 8'h00};
		issue(FWUS_CMD_GETCAP, 8'h00, `FWUS_RC_SUCCESS);
		issue(FWUS_CMD_SELFTEST, 8'h00, `FWUS_RC_SUCCESS);
		r = $random(seed);
		selftest_pass <= r;
		selftest_done <= 1'b1;
		@(posedge clk_sys);
		selftest_done <= 1'b0;
		xl = 8'h0b;
		xp = {r & 32'h0026_8070, 32'h0, 16'h0, 8'h01};
		xm = '1;
		issue(FWUS_CMD_TESTRESULT, 8'h00, `FWUS_RC_SUCCESS);
		issue(FWUS_CMD_FINALIZE, 8'h00, `FWUS_RC_FAILURE);
		slow <= 1'b1;
		big <= 1'b1;
		issue(FWUS_CMD_IMAGE, 8'h00, `FWUS_RC_COMMAND_SIZE);
		big <= 1'b0;
		repeat (3) issue(FWUS_CMD_IMAGE, 8'h00, `FWUS_RC_SUCCESS);
		issue(FWUS_CMD_ABORT, 8'h00, `FWUS_RC_DISABLED);
		cmd_reserved_zero <= 1'b0;
		issue(FWUS_CMD_FINALIZE, 8'h00, `FWUS_RC_FAILURE);
		cmd_reserved_zero <= 1'b1;
		issue(FWUS_CMD_FINALIZE, 8'h00, `FWUS_RC_REBOOT);
		issue(FWUS_CMD_MANIFEST, 8'h01, `FWUS_RC_REBOOT);
		slow <= 1'b0;
		drain();
		restore_abort_lock <= 1'b1;
		rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		issue(FWUS_CMD_ABORT, 8'h00, `FWUS_RC_DISABLED);
		issue(FWUS_CMD_MANIFEST, 8'h01, `FWUS_RC_SUCCESS);
		issue(FWUS_CMD_MANIFEST, 8'h00, `FWUS_RC_SUCCESS);
		drain();
		restore_abort_lock <= 1'b0;
		manifest_verify_ok <= 1'b0;
		rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		for (int k = 0; k < 256; k++) begin
			issue(FWUS_CMD_MANIFEST, 8'h01, `FWUS_RC_SUCCESS);
			issue(FWUS_CMD_MANIFEST, 8'h00, `FWUS_RC_AUTH_FAIL);
		end
		issue(FWUS_CMD_MANIFEST, 8'h01, `FWUS_RC_FAILURE);
		drain();
		close_out();
	end
endmodule

bind fwus_seq fwus_seq_properties chk (.clk_sys, .rst, .cmd_valid, .cmd_ready, .cmd_code,
	.cmd_tag_ok, .cmd_size_ok, .cmd_locality_ok, .cmd_len, .rsp_valid, .rsp_ready, .rsp_code,
	.image_block_write, .finalize_start, .abort_start, .attempt_count, .manifest_done,
	.data_started, .abort_allowed, .selftest_start);

`default_nettype wire
